// *** addr_tbl_model.sv ***
// address table responder standing in for the lookup memories
`timescale 1ns/100ps
module addr_tbl_model
	import fwd_pkg::*;
#(
	parameter int N = 7
)
(
	// clock
	input wire logic             ref_clk,
	// request
	input wire logic             addr_req,
	input wire logic [FID_W-1:0] addr_req_fid,
	// behaviour chosen by the bench
	input wire logic             hit,
	input wire logic             sa_hit,
	input wire logic [N-1:0]     ports,
	input wire logic [1:0]       lat,
	// answer
	output logic                 addr_rsp_valid,
	output logic                 dyn_hit,
	output logic [FID_W-1:0]     dyn_fid,
	output logic [N-1:0]         dyn_ports,
	output logic                 sa_found,
	output logic [FID_W-1:0]     sa_fid
);
	logic [2:0]       cnt_q = 3'h0;
	logic [FID_W-1:0] fid_q = '0;
	// countdown from the request, slow or prompt as the bench asks
	always @(posedge ref_clk)
	begin
		if (addr_req)
		begin
			cnt_q <= {1'b0, lat} + 3'h1;
			fid_q <= addr_req_fid;
		end
		else if (cnt_q != 3'h0)
			cnt_q <= cnt_q - 3'h1;
	end
	// fields only meaningful with the pulse, scrambled otherwise
	assign addr_rsp_valid = (cnt_q == 3'h1);
	assign dyn_hit   = addr_rsp_valid ? hit : ~hit;
	assign dyn_fid   = addr_rsp_valid ? fid_q : ~fid_q;
	assign dyn_ports = addr_rsp_valid ? ports : ~ports;
	assign sa_found  = addr_rsp_valid ? sa_hit : ~sa_hit;
	assign sa_fid    = addr_rsp_valid ? fid_q : ~fid_q;
endmodule : addr_tbl_model

// *** fwd_decision.sv ***
// per-frame forwarding decision: vlan table, address result, port vlan, acl
// Behaviour
// - address lookup mask, then later stages modify it
// - acl result overrides, evaluated beside lookup
// - errored and management frames never forwarded
// - pause frames consumed, drive flow control
// - address hit on ingress port drops frame
// - per-ingress egress mask applied unless acl overrides, default all
// - vlan table with 4k entries
// - vlan mode indexes table by vid, checks valid
// - invalid vid: drop, unknown list or host
// - fid joins address lookup, fid must match
// - address miss floods vlan members
// - egress filtering ands address and members
// - filtering off uses address list alone
// - source miss learns address with fid
// - untagged or null vid uses port default
// - reset default vid 1, entry 1 all members
// - vlan table used even with vlan off
// - vlan enable at control0 bit 7
// - drop invalid at control0 bit 6, default one
// - egress filtering at control2 bits 5,4
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/100ps
module fwd_decision
	import fwd_pkg::*;
#(
	parameter int N = 7
)
(
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 sys_rst,
	// register port
	input  wire logic [7:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_we,
	input  wire logic                 reg_re,
	output logic      [31:0]          reg_rdata,
	// parsed frame header from the port macs
	input  wire logic                 hdr_valid,
	output logic                      hdr_ready,
	input  wire logic [$clog2(N)-1:0] hdr_src_port,
	input  wire logic                 hdr_tagged,
	input  wire logic [VID_W-1:0]     hdr_vid,
	input  wire logic                 hdr_rx_error,
	input  wire logic                 hdr_mgmt,
	input  wire logic                 hdr_pause,
	input  wire logic                 hdr_sa_unicast,
	// later-stage and acl results for the same frame
	input  wire logic [N-1:0]         stage_keep_mask,
	input  wire logic [N-1:0]         stage_add_mask,
	input  wire logic                 acl_override,
	input  wire logic [N-1:0]         acl_port_mask,
	// address table lookup
	output logic                      addr_req,
	output logic      [FID_W-1:0]     addr_req_fid,
	input  wire logic                 addr_rsp_valid,
	input  wire logic                 sta_hit,
	input  wire logic                 sta_use_fid,
	input  wire logic [FID_W-1:0]     sta_fid,
	input  wire logic [N-1:0]         sta_ports,
	input  wire logic                 dyn_hit,
	input  wire logic [FID_W-1:0]     dyn_fid,
	input  wire logic [N-1:0]         dyn_ports,
	input  wire logic                 sa_found,
	input  wire logic [FID_W-1:0]     sa_fid,
	// decision, learning and flow control
	output logic                      dec_valid,
	output logic      [N-1:0]         final_port_mask,
	output logic                      learn_valid,
	output logic      [FID_W-1:0]     learn_fid,
	output logic      [$clog2(N)-1:0] learn_port,
	output logic                      pause_valid,
	output logic      [N-1:0]         pause_port
);

	localparam int PIW = $clog2(N);

	typedef struct packed {
		st_t                  st;
		logic [11:0]          init_cnt;
		logic [7:0]           ctrl0;
		logic [1:0]           egf;
		logic                 unk_en;
		logic [N-1:0]         unk_list;
		logic [11:0]          vt_index;
		logic [VT_W-1:0]      vt_wdata;
		logic [N-1:0][11:0]   dvid;
		logic [N-1:0][N-1:0]  egr;
		logic [31:0]          rdata;
		logic [PIW-1:0]       src;
		logic [N-1:0]         keep;
		logic [N-1:0]         add;
		logic                 acl_ovr;
		logic [N-1:0]         acl_mask;
		logic                 sa_uni;
		logic [FID_W-1:0]     filtering_group_identifier;
		logic [N-1:0]         members;
		logic                 fwd_opt;
		logic [N-1:0]         fmask;
		logic                 areq;
		logic                 learn;
		logic                 pause;
		logic [15:0]          dec_cnt;
		logic [15:0]          drop_cnt;
	} state_t;

	state_t r_q;
	state_t r_d;

	vlan_tbl_if #(.AW(VID_W), .W(VT_W)) vt ();

	// vlan table, 4k entries
	vlan_table_mem #(.DEPTH(VT_DEPTH), .W(VT_W)) u_vt
	(
		.ref_clk (ref_clk),
		.tb      (vt.mem)
	);

	// ====================================================================
	// helpers

	// per-port register window decode
	function automatic logic port_hit(input logic [7:0] a, input logic [7:0] base);
		port_hit = (a[7:6] == base[7:6]) && (a[1:0] == 2'h0) && (32'(a[5:2]) < N);
	endfunction : port_hit

	// later stages, port vlan, ingress exclusion and acl override
	function automatic logic [N-1:0] finish(input logic [N-1:0] pre, input state_t s,
		input logic [N-1:0] srcbit);
		logic [N-1:0] m;
		m = (pre & s.keep) | s.add;
		m = m & s.egr[s.src] & ~srcbit;
		if (s.acl_ovr)
			m = s.acl_mask;
		finish = m;
	endfunction : finish

	// ====================================================================
	// frame-side combinational terms
	logic [VID_W-1:0] look_vid;
	logic             vlan_en;
	logic             bad_frame;

	assign vlan_en   = r_q.ctrl0[VLAN_EN_BIT];
	assign bad_frame = hdr_rx_error | hdr_mgmt | hdr_pause;

	// lookup vid: tag vid only in vlan mode with a non-null tag
	always_comb
	begin
		look_vid = r_q.dvid[hdr_src_port];
		if (vlan_en && hdr_tagged && (hdr_vid != '0))
			look_vid = hdr_vid;
	end

	// ====================================================================
	// table ports: init sweep has the write port, then software
	always_comb
	begin
		vt.rd_en   = (r_q.st == ST_IDLE) && hdr_valid;
		vt.rd_addr = look_vid;
		if (r_q.st == ST_INIT)
		begin
			vt.wr_en   = 1'b1;
			vt.wr_addr = r_q.init_cnt;
			vt.wr_data = (r_q.init_cnt == DEF_VID) ? VT_DEF_ENT : '0;
		end
		else
		begin
			vt.wr_en   = reg_we && (reg_addr == OFF_VT_DATA);
			vt.wr_addr = r_q.vt_index;
			vt.wr_data = reg_wdata[VT_W-1:0];
		end
	end

	// ====================================================================
	// next state
	always_comb
	begin
		logic [N-1:0]      srcbit;
		logic [VT_W-1:0]   ent;
		logic              s_ok;
		logic              d_ok;
		logic              hit;
		logic              sa_ok;
		logic [N-1:0]      aports;
		logic [N-1:0]      pre;
		logic [N-1:0]      host;
		srcbit = '0;
		ent    = vt.rd_data;
		s_ok   = 1'b0;
		d_ok   = 1'b0;
		hit    = 1'b0;
		sa_ok  = 1'b0;
		aports = '0;
		pre    = '0;
		host   = '0;
		host[N-1]     = 1'b1;
		srcbit[r_q.src] = 1'b1;
		r_d       = r_q;
		r_d.rdata = '0;
		r_d.areq  = 1'b0;
		r_d.learn = 1'b0;
		r_d.pause = 1'b0;

		// register writes
		if (reg_we)
		begin
			case (reg_addr)
				OFF_LUE_CTRL0: r_d.ctrl0 = reg_wdata[7:0];
				OFF_LUE_CTRL2: r_d.egf = reg_wdata[EGF_HI_BIT:EGF_LO_BIT];
				OFF_UNK_VID:
				begin
					r_d.unk_en   = reg_wdata[UNK_FWD_BIT];
					r_d.unk_list = reg_wdata[N-1:0];
				end
				OFF_VT_INDEX:  r_d.vt_index = reg_wdata[11:0];
				OFF_VT_DATA:   r_d.vt_wdata = reg_wdata[VT_W-1:0];
				default:
				begin
					if (port_hit(reg_addr, OFF_DVID_BASE))
						r_d.dvid[reg_addr[5:2]] = reg_wdata[11:0];
					if (port_hit(reg_addr, OFF_EGR_BASE))
						r_d.egr[reg_addr[5:2]] = reg_wdata[N-1:0];
				end
			endcase
		end

		// register reads, data stand one cycle later
		if (reg_re)
		begin
			case (reg_addr)
				OFF_LUE_CTRL0: r_d.rdata = {24'h0, r_q.ctrl0};
				OFF_LUE_CTRL2: r_d.rdata = 32'({r_q.egf, 4'h0});
				OFF_UNK_VID:   r_d.rdata = {r_q.unk_en, 31'(r_q.unk_list)};
				OFF_VT_INDEX:  r_d.rdata = {20'h0, r_q.vt_index};
				OFF_VT_DATA:   r_d.rdata = 32'(r_q.vt_wdata);
				OFF_STATUS:    r_d.rdata = {r_q.drop_cnt, r_q.dec_cnt};
				OFF_STATE:     r_d.rdata = {29'h0, r_q.st};
				default:
				begin
					if (port_hit(reg_addr, OFF_DVID_BASE))
						r_d.rdata = {20'h0, r_q.dvid[reg_addr[5:2]]};
					if (port_hit(reg_addr, OFF_EGR_BASE))
						r_d.rdata = 32'(r_q.egr[reg_addr[5:2]]);
				end
			endcase
		end

		// decision sequencer
		case (r_q.st)
			ST_INIT:
			begin
				r_d.init_cnt = r_q.init_cnt + 12'h001;
				if (r_q.init_cnt == VT_LAST)
					r_d.st = ST_IDLE;
			end
			ST_IDLE:
			begin
				if (hdr_valid)
				begin
					r_d.src      = hdr_src_port;
					r_d.keep     = stage_keep_mask;
					r_d.add      = stage_add_mask;
					r_d.acl_ovr  = acl_override;
					r_d.acl_mask = acl_port_mask;
					r_d.sa_uni   = hdr_sa_unicast;
					if (bad_frame)
					begin
						r_d.fmask    = '0;
						r_d.pause    = hdr_pause && !hdr_rx_error;
						r_d.drop_cnt = r_q.drop_cnt + 16'h0001;
						r_d.st       = ST_DONE;
					end
					else
						r_d.st = ST_VRD;
				end
			end
			ST_VRD:
			begin
				r_d.filtering_group_identifier     = ent[VT_FID_LSB +: FID_W];
				r_d.members = ent[N-1:0];
				r_d.fwd_opt = ent[VT_FWDOPT];
				if (vlan_en && !ent[VT_VALID])
				begin
					// invalid vid: no address lookup, no learning
					if (r_q.unk_en)
						pre = r_q.unk_list;
					else if (r_q.ctrl0[DROP_INV_BIT])
						pre = '0;
					else
						pre = host;
					r_d.fmask = finish(pre, r_q, srcbit);
					r_d.st    = ST_DONE;
				end
				else
				begin
					r_d.areq = 1'b1;
					r_d.st   = ST_ADDR;
				end
			end
			ST_ADDR:
			begin
				if (addr_rsp_valid)
				begin
					// static entries win over dynamic ones
					s_ok   = sta_hit && (!vlan_en || !sta_use_fid || (sta_fid == r_q.filtering_group_identifier));
					d_ok   = dyn_hit && (!vlan_en || (dyn_fid == r_q.filtering_group_identifier));
					hit    = s_ok || d_ok;
					aports = s_ok ? sta_ports : dyn_ports;
					if (!hit)
						pre = r_q.members;
					else if (vlan_en && r_q.fwd_opt)
						pre = r_q.members;
					else if (vlan_en && (r_q.egf != 2'h0))
						pre = aports & r_q.members;
					else
						pre = aports;
					r_d.fmask = finish(pre, r_q, srcbit);
					if (hit && (aports == srcbit) && !r_q.acl_ovr)
						r_d.fmask = '0;
					sa_ok     = sa_found && (!vlan_en || (sa_fid == r_q.filtering_group_identifier));
					r_d.learn = !sa_ok && r_q.sa_uni;
					r_d.st    = ST_DONE;
				end
			end
			ST_DONE:
			begin
				r_d.dec_cnt = r_q.dec_cnt + 16'h0001;
				r_d.st      = ST_IDLE;
			end
			default: r_d.st = ST_IDLE;
		endcase
	end

	// ====================================================================
	// state register
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			r_q          <= '0;
			r_q.st       <= ST_INIT;
			r_q.ctrl0    <= CTRL0_RST;
			r_q.dvid     <= {N{DEF_VID}};
			r_q.egr      <= {(N*N){1'b1}};
		end
		else
			r_q <= r_d;
	end

	// ====================================================================
	// outputs
	assign hdr_ready       = (r_q.st == ST_IDLE);
	assign dec_valid       = (r_q.st == ST_DONE);
	assign final_port_mask = r_q.fmask;
	assign reg_rdata       = r_q.rdata;
	assign addr_req        = r_q.areq;
	assign addr_req_fid    = r_q.filtering_group_identifier;
	assign learn_valid     = r_q.learn;
	assign learn_fid       = r_q.filtering_group_identifier;
	assign learn_port      = r_q.src;
	assign pause_valid     = r_q.pause;

	// flow control request on the receiving port
	always_comb
	begin
		pause_port = '0;
		pause_port[r_q.src] = 1'b1;
	end

endmodule : fwd_decision

// *** fwd_decision_checker.sv ***
// port assertions for the forwarding decision block
`timescale 1ns/100ps
module fwd_decision_checker
#(
	parameter int N = 7
)
(
	// clock and reset
	input wire logic                 ref_clk,
	input wire logic                 sys_rst,
	// frame side
	input wire logic                 hdr_valid,
	input wire logic                 hdr_ready,
	input wire logic [$clog2(N)-1:0] hdr_src_port,
	input wire logic                 hdr_rx_error,
	input wire logic                 hdr_mgmt,
	input wire logic                 hdr_pause,
	input wire logic                 acl_override,
	input wire logic [N-1:0]         acl_port_mask,
	input wire logic                 addr_rsp_valid,
	// results
	input wire logic                 dec_valid,
	input wire logic [N-1:0]         final_port_mask,
	input wire logic                 learn_valid,
	input wire logic                 pause_valid,
	input wire logic [N-1:0]         pause_port
);
	// ==========
	// frame attributes held from acceptance
	logic                 take;
	logic                 bad;
	logic                 acl_q;
	logic                 bad_q;
	logic [N-1:0]         aclm_q;
	logic [$clog2(N)-1:0] src_q;
	assign take = hdr_valid && hdr_ready;
	assign bad  = hdr_rx_error || hdr_mgmt || hdr_pause;
	// capture at the taking edge
	always_ff @(posedge ref_clk)
	begin
		if (take)
		begin
			acl_q  <= acl_override;
			bad_q  <= bad;
			aclm_q <= acl_port_mask;
			src_q  <= hdr_src_port;
		end
	end
	// ==========
	// properties
	default clocking dc @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence s_take_bad;
		take && bad;
	endsequence
	sequence s_dec_none;
		dec_valid && final_port_mask == '0;
	endsequence
	bad_frame_drop_a: assert property (s_take_bad |=> s_dec_none)
		else $error("bad frame forwarded");
	pause_flow_a: assert property (take && hdr_pause && !hdr_rx_error |=> pause_valid)
		else $error("pause frame without flow control");
	pause_port_a: assert property (pause_valid |-> pause_port[src_q] && $onehot(pause_port))
		else $error("pause on wrong port");
	bad_no_learn_a: assert property (s_take_bad |=> !learn_valid)
		else $error("bad frame learned");
	learn_with_dec_a: assert property (learn_valid |-> dec_valid)
		else $error("learning outside decision");
	rsp_to_dec_a: assert property (addr_rsp_valid |=> dec_valid)
		else $error("no decision after lookup answer");
	acl_wins_a: assert property (dec_valid && acl_q && !bad_q |-> final_port_mask == aclm_q)
		else $error("acl result not final");
	ingress_excl_a: assert property (dec_valid && !acl_q |-> !final_port_mask[src_q])
		else $error("frame sent back to ingress");
	ready_after_a: assert property (dec_valid |-> !hdr_ready ##1 hdr_ready)
		else $error("header accept timing wrong");
	sweep_busy_a: assert property ($fell(sys_rst) |-> !hdr_ready [*8])
		else $error("ready during table sweep");
endmodule : fwd_decision_checker

bind fwd_decision fwd_decision_checker #(.N(N)) chk (.*);

// *** fwd_pkg.sv ***
// constants shared by the forwarding decision block and its vlan table memory
package fwd_pkg;

	// ====================================================================
	// register offsets (byte addresses on the plain register port)
	localparam logic [7:0] OFF_LUE_CTRL0 = 8'h00;
	localparam logic [7:0] OFF_LUE_CTRL2 = 8'h08;
	localparam logic [7:0] OFF_UNK_VID   = 8'h10;
	localparam logic [7:0] OFF_VT_INDEX  = 8'h14;
	localparam logic [7:0] OFF_VT_DATA   = 8'h18;
	localparam logic [7:0] OFF_STATUS    = 8'h1C;
	localparam logic [7:0] OFF_STATE     = 8'h20;
	localparam logic [7:0] OFF_DVID_BASE = 8'h40;
	localparam logic [7:0] OFF_EGR_BASE  = 8'h80;

	// ====================================================================
	// field positions
	localparam int VLAN_EN_BIT  = 7;
	localparam int DROP_INV_BIT = 6;
	localparam int EGF_HI_BIT   = 5;
	localparam int EGF_LO_BIT   = 4;
	localparam int UNK_FWD_BIT  = 31;
	localparam int VT_FID_LSB   = 16;
	localparam int VT_FWDOPT    = 24;
	localparam int VT_VALID     = 25;

	// ====================================================================
	// sizes and reset values
	localparam int          VID_W      = 12;
	localparam int          FID_W      = 7;
	localparam int          VT_W       = 26;
	localparam int          VT_DEPTH   = 4096;
	localparam int          MAX_PORTS  = 16;
	localparam logic [7:0]  CTRL0_RST  = 8'h40;
	localparam logic [11:0] DEF_VID    = 12'h001;
	localparam logic [11:0] VT_LAST    = 12'hFFF;
	localparam logic [25:0] VT_DEF_ENT = 26'h200FFFF;

	// ====================================================================
	// decision sequencer states, gray from ST_INIT along the lookup path to ST_DONE, not on the return to ST_IDLE
	typedef enum logic [2:0]
	{
		ST_INIT = 3'h0,
		ST_IDLE = 3'h1,
		ST_VRD  = 3'h3,
		ST_ADDR = 3'h2,
		ST_DONE = 3'h6
	} st_t;

endpackage : fwd_pkg

// *** tb_switch_forwarding_vlan_decision.sv ***
// self-checking bench for the forwarding decision block
`timescale 1ns/100ps
module tb_switch_forwarding_vlan_decision
	import fwd_pkg::*;
;
	localparam int N = 7;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic reg_we = 1'b0;
	logic reg_re = 1'b0;
	logic hdr_valid = 1'b0;
	logic hdr_tagged = 1'b0;
	logic hdr_rx_error = 1'b0;
	logic hdr_mgmt = 1'b0;
	logic hdr_pause = 1'b0;
	logic hdr_sa_unicast = 1'b1;
	logic acl_override = 1'b0;
	logic hit = 1'b0;
	logic sa_hit = 1'b0;
	logic sta_hit = 1'b0;
	logic sta_use_fid = 1'b0;
	logic [FID_W-1:0] sta_fid = '0;
	logic [N-1:0] sta_ports = '0;
	logic [2:0] hdr_src_port = 3'h0;
	logic [11:0] hdr_vid = 12'h000;
	logic [N-1:0] ports = '0;
	logic [N-1:0] stage_keep_mask = '1;
	logic [N-1:0] stage_add_mask = '0;
	logic [N-1:0] acl_port_mask = '0;
	logic [1:0] lat = 2'h0;
	logic hdr_ready, addr_req, addr_rsp_valid, dec_valid, dyn_hit, sa_found;
	logic [FID_W-1:0] addr_req_fid, dyn_fid, sa_fid;
	logic [N-1:0] dyn_ports, final_port_mask;
	logic [N-1:0] egr [N];
	int errors = 0;
	int checks_done = 0;

	// ==========
	// clock, design and far side
	always #4 ref_clk = ~ref_clk;
	fwd_decision #(.N(N)) dut (.*, .learn_valid(), .learn_fid(), .learn_port(),
		.pause_valid(), .pause_port());
	addr_tbl_model #(.N(N)) far (.*);

	// ==========
	// compare, register and frame tasks
	task automatic cmp_mask(input string what, input logic [N-1:0] e, input logic [N-1:0] g);
		checks_done++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected %s exp %h got %h", what, e, g);
		end
	endtask : cmp_mask
	task automatic cmp_word(input string what, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected %s exp %h got %h", what, e, g);
		end
	endtask : cmp_word
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_we <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_re <= 1'b0;
		@(negedge ref_clk);
		cmp_word("register", e, reg_rdata);
		// hand back on a rising edge so callers drive inputs there
		@(posedge ref_clk);
	endtask : rd
	// neutral frame fields with the chosen ingress and lookup outcome
	task automatic clean(input logic [2:0] s, input logic h, input logic [N-1:0] p,
		input logic t, input logic [11:0] v);
		hdr_src_port <= s;
		hit <= h;
		ports <= p;
		hdr_tagged <= t;
		hdr_vid <= v;
		{hdr_rx_error, hdr_mgmt, hdr_pause, acl_override} <= 4'h0;
		stage_keep_mask <= '1;
		stage_add_mask <= '0;
	endtask : clean
	// offer one header, work out the mask, wait for the decision
	task automatic send(input logic [N-1:0] mem, input logic filt);
		logic [N-1:0] sb;
		logic [N-1:0] e;
		int n;
		@(posedge ref_clk);
		hdr_valid <= 1'b1;
		sb = N'(1) << hdr_src_port;
		e = !hit ? mem : (filt ? ports & mem : ports);
		e = ((e & stage_keep_mask) | stage_add_mask) & egr[hdr_src_port] & ~sb;
		if (hit && ports == sb)
			e = '0;
		if (acl_override)
			e = acl_port_mask;
		if (hdr_rx_error || hdr_mgmt || hdr_pause)
			e = '0;
		n = 0;
		do
		begin
			@(negedge ref_clk);
			n++;
		end
		while (hdr_ready !== 1'b1 && n < 5000);
		@(posedge ref_clk);
		hdr_valid <= 1'b0;
		n = 0;
		do
		begin
			@(negedge ref_clk);
			n++;
		end
		while (dec_valid !== 1'b1 && n < 50);
		cmp_mask("port mask", e, dec_valid === 1'b1 ? final_port_mask : ~e);
		// hand back on a rising edge so callers drive inputs there
		@(posedge ref_clk);
	endtask : send
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish

	// ==========
	// watchdog well beyond the sweep and all frames
	initial
	begin
		repeat (30000) @(posedge ref_clk);
		errors++;
		tally_and_finish();
	end
	// main sequence
	initial
	begin
		void'($urandom(32'hAAE31774));
		foreach (egr[p])
			egr[p] = '1;
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(OFF_LUE_CTRL0, 32'h00000040);
		rd(OFF_LUE_CTRL2, 32'h00000000);
		rd(OFF_DVID_BASE + 8'h0C, 32'h00000001);
		rd(8'hFC, 32'h00000000);
		wr(OFF_EGR_BASE + 8'h08, 32'h00000055);
		egr[2] = 7'h55;
		$display("reset values done");
		clean(3'h2, 1'b1, 7'h04, 1'b0, 12'h000);
		send(7'h7F, 1'b0);
		clean(3'h2, 1'b0, 7'h00, 1'b0, 12'h000);
		send(7'h7F, 1'b0);
		for (int i = 0; i < 40; i++)
		begin
			hdr_src_port <= 3'($urandom % 7);
			hit <= 1'($urandom);
			ports <= 7'($urandom);
			hdr_tagged <= 1'($urandom);
			hdr_vid <= 12'($urandom);
			stage_keep_mask <= 7'($urandom | 32'h78);
			stage_add_mask <= ($urandom % 4 == 0) ? 7'($urandom) : 7'h00;
			acl_override <= ($urandom % 4 == 0);
			acl_port_mask <= 7'($urandom);
			hdr_rx_error <= ($urandom % 8 == 0);
			hdr_mgmt <= ($urandom % 8 == 0);
			hdr_pause <= ($urandom % 8 == 0);
			hdr_sa_unicast <= 1'($urandom);
			sa_hit <= 1'($urandom);
			lat <= 2'($urandom);
			send(7'h7F, 1'b0);
		end
		$display("random frames done");
		wr(OFF_VT_INDEX, 32'h00000009);
		wr(OFF_VT_DATA, 32'h0203000F);
		rd(OFF_VT_DATA, 32'h0203000F);
		wr(OFF_DVID_BASE + 8'h04, 32'h00000009);
		wr(OFF_LUE_CTRL0, 32'h000000C0);
		rd(OFF_LUE_CTRL0, 32'h000000C0);
		clean(3'h1, 1'b0, 7'h00, 1'b1, 12'h009);
		send(7'h0F, 1'b0);
		clean(3'h1, 1'b1, 7'h31, 1'b0, 12'h000);
		send(7'h0F, 1'b0);
		wr(OFF_LUE_CTRL2, 32'h00000030);
		clean(3'h1, 1'b1, 7'h31, 1'b1, 12'h000);
		send(7'h0F, 1'b1);
		clean(3'h1, 1'b0, 7'h00, 1'b1, 12'h005);
		send(7'h00, 1'b0);
		wr(OFF_LUE_CTRL0, 32'h00000080);
		send(7'h40, 1'b0);
		wr(OFF_UNK_VID, 32'h80000006);
		send(7'h06, 1'b0);
		rd(OFF_STATE, 32'h00000001);
		$display("vlan mode done");
		tally_and_finish();
	end
endmodule : tb_switch_forwarding_vlan_decision

// *** vlan_table_mem.sv ***
// vlan table storage, one write port and one registered read port
`timescale 1ns/100ps
module vlan_table_mem
	import fwd_pkg::*;
#(
	parameter int DEPTH = VT_DEPTH,
	parameter int W     = VT_W
)
(
	// clock
	input wire logic  ref_clk,
	// table access
	vlan_tbl_if.mem   tb
);

	logic [W-1:0] mem [DEPTH];
	logic [W-1:0] rd_q;

	// ====================================================================
	// write, then registered read
	always_ff @(posedge ref_clk)
	begin
		if (tb.wr_en)
			mem[tb.wr_addr] <= tb.wr_data;
		if (tb.rd_en)
			rd_q <= mem[tb.rd_addr];
	end

	assign tb.rd_data = rd_q;

endmodule : vlan_table_mem

// *** vlan_tbl_if.sv ***
// connection between the decision block and the vlan table memory
`timescale 1ns/100ps
interface vlan_tbl_if #(parameter int AW = 12, parameter int W = 26);
	logic          rd_en;
	logic [AW-1:0] rd_addr;
	logic [W-1:0]  rd_data;
	logic          wr_en;
	logic [AW-1:0] wr_addr;
	logic [W-1:0]  wr_data;

	modport mem  (input rd_en, rd_addr, wr_en, wr_addr, wr_data, output rd_data);
	modport user (output rd_en, rd_addr, wr_en, wr_addr, wr_data, input rd_data);
endinterface : vlan_tbl_if
